// ### rtl/pcw_dev.sv
// receiver end: pulse-count register writer with enable and shutdown
// Behaviour
// - write-only single wire, 32 register addresses
// - address train, hold, data train, hold
// - enable after long enough high level
// - disable after long enough low level
// - shutdown resets every register to default
// - address is rising edges minus one
// - address captured after address hold high
// - short hold keeps adding to address count
// - over 31 drops write after hold
// - overlong address hold drops the transaction
// - data is rising edges minus one
// - data taken only after data hold
// - over 63 drops write after hold
// - after data hold expect address again
// - host sends address before every data
// - host keeps hold spacing within limits
// - long high after transfer enters standby
// - uneven pulse widths are accepted
// - stretched high pulse shorter than the address hold does not end address phase
// - over-temperature disables outputs, keeps registers
// - write-only, unused addresses 3 and 4
`default_nettype none
module pcw_dev #(
  parameter int unsigned ENABLE_CYC   = pcw_pkg::ENABLE_CYC,
  parameter int unsigned SHUTDOWN_CYC = pcw_pkg::SHUTDOWN_CYC,
  parameter int unsigned AHOLD_MIN    = pcw_pkg::ADDR_HOLD_MIN_CYC,
  parameter int unsigned AHOLD_MAX    = pcw_pkg::ADDR_HOLD_MAX_CYC,
  parameter int unsigned DHOLD_CYC    = pcw_pkg::DATA_HOLD_CYC,
  parameter int unsigned STANDBY_CYC  = pcw_pkg::STANDBY_CYC
) (
  input  wire logic                       sys_clk_in,
  input  wire logic                       rstn_in,
  pcw_link_if.dev                         link,
  input  wire logic                       over_temperature_in,
  output logic                            enabled_out,
  output logic                            outputs_on_out,
  output logic                            standby_out,
  output logic                            write_strobe_out,
  output logic [pcw_pkg::ADDR_W-1:0]      write_addr_out,
  output logic [pcw_pkg::DATA_W-1:0]      write_data_out,
  output logic [pcw_pkg::NUM_REGS*pcw_pkg::DATA_W-1:0] regs_out
);
  localparam int unsigned AW = pcw_pkg::ADDR_W;
  localparam int unsigned DW = pcw_pkg::DATA_W;
  localparam int unsigned CW = pcw_pkg::CNT_W;
  localparam logic [CW-1:0] ENA_C = CW'(ENABLE_CYC);
  localparam logic [CW-1:0] SD_C  = CW'(SHUTDOWN_CYC);
  localparam logic [CW-1:0] AMIN_C = CW'(AHOLD_MIN);
  localparam logic [CW-1:0] AMAX_C = CW'(AHOLD_MAX);
  localparam logic [CW-1:0] DH_C  = CW'(DHOLD_CYC);
  localparam logic [CW-1:0] SB_C  = CW'(STANDBY_CYC);
  localparam logic [1:0]    FLT_C = 2'(pcw_pkg::FILT_CYC);

  // ==========================================================
  // synchroniser and glitch filter
  logic       s1_q, s2_q, pin_q, pin_d, pin_prev_q;
  logic [1:0] flt_q, flt_d;
  always_comb begin
    pin_d = pin_q;
    flt_d = 2'h0;
    if (s2_q != pin_q) begin
      flt_d = flt_q + 2'h1;
      if (flt_q + 2'h1 >= FLT_C) begin
        pin_d = s2_q;
        flt_d = 2'h0;
      end
    end
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_q       <= 1'b0;
      s2_q       <= 1'b0;
      pin_q      <= 1'b0;
      pin_prev_q <= 1'b0;
      flt_q      <= 2'h0;
    end else begin
      s1_q       <= link.command_pin;
      s2_q       <= s1_q;
      pin_q      <= pin_d;
      pin_prev_q <= pin_q;
      flt_q      <= flt_d;
    end
  end
  wire rise = pin_q & ~pin_prev_q;

  // ==========================================================
  // level timer, enable and shutdown
  logic [CW-1:0] lvl_q, lvl_d;
  logic          en_q, en_d, sb_q, sb_d;
  always_comb begin
    lvl_d = (pin_q != pin_prev_q) ? CW'(0) : ((lvl_q == SB_C) ? lvl_q : lvl_q + CW'(1));
    en_d  = en_q;
    sb_d  = sb_q;
    // lvl_q still times the old level in the cycle the filtered pin changes
    if (pin_q && pin_prev_q && !en_q && lvl_q >= ENA_C) en_d = 1'b1;
    if (!pin_q && !pin_prev_q && en_q && lvl_q >= SD_C) en_d = 1'b0;
    if (rise) sb_d = 1'b0;
    else if (pin_q && en_q && lvl_q >= SB_C) sb_d = 1'b1;
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lvl_q <= '0;
      en_q  <= 1'b0;
      sb_q  <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      en_q  <= en_d;
      sb_q  <= sb_d;
    end
  end

  // ==========================================================
  // pulse counting receiver
  pcw_pkg::pcw_phase_t ph_q, ph_d;
  logic [DW:0]   cnt_q, cnt_d;
  logic [AW-1:0] adr_q, adr_d;
  logic          held_q, held_d, wr_d;
  logic [DW-1:0] wdat_d;
  always_comb begin
    ph_d   = ph_q;
    cnt_d  = cnt_q;
    adr_d  = adr_q;
    held_d = held_q;
    wr_d   = 1'b0;
    wdat_d = '0;
    if (!en_q || sb_d) begin
      ph_d   = pcw_pkg::PCW_ADDR;
      cnt_d  = '0;
      held_d = 1'b0;
    end else if (rise) begin
      held_d = 1'b0;
      if (cnt_q != {(DW+1){1'b1}}) cnt_d = cnt_q + 1'b1;
    end else if (pin_q && !held_q && cnt_q != '0) begin
      // edges are counted so far; hold decisions use the high time
      case (ph_q)
        pcw_pkg::PCW_ADDR: begin
          if (lvl_q >= AMIN_C) begin
            held_d = 1'b1;
            cnt_d  = '0;
            if (cnt_q > (DW+1)'(pcw_pkg::NUM_REGS)) ph_d = pcw_pkg::PCW_ADDR;
            else begin
              adr_d = AW'(cnt_q - 1'b1);
              ph_d  = pcw_pkg::PCW_DATA;
            end
          end
        end
        pcw_pkg::PCW_DATA: begin
          if (lvl_q >= DH_C) begin
            held_d = 1'b1;
            cnt_d  = '0;
            ph_d   = pcw_pkg::PCW_ADDR;
            if (cnt_q <= {1'b1, {DW{1'b0}}}) begin
              wr_d   = 1'b1;
              wdat_d = DW'(cnt_q - 1'b1);
            end
          end
        end
        default: ph_d = pcw_pkg::PCW_ADDR;
      endcase
    end else if (pin_q && held_q && ph_q == pcw_pkg::PCW_DATA && cnt_q == '0 && lvl_q > AMAX_C) begin
      ph_d = pcw_pkg::PCW_ADDR;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ph_q   <= pcw_pkg::PCW_ADDR;
      cnt_q  <= '0;
      adr_q  <= '0;
      held_q <= 1'b0;
    end else begin
      ph_q   <= ph_d;
      cnt_q  <= cnt_d;
      adr_q  <= adr_d;
      held_q <= held_d;
    end
  end

  // ==========================================================
  // register space, write only
  logic [DW-1:0] regs_q [pcw_pkg::NUM_REGS];
  logic          stb_q;
  logic [AW-1:0] wa_q;
  logic [DW-1:0] wd_q;
  logic          oo_q;
  genvar gi;
  for (gi = 0; gi < pcw_pkg::NUM_REGS; gi++) begin : g_reg
    localparam logic [AW-1:0] IDX = AW'(gi);
    logic [DW-1:0] nx;
    always_comb begin
      nx = regs_q[gi];
      if (!en_q) nx = pcw_pkg::REG_RESET;
      else if (wr_d && adr_q == IDX && IDX != pcw_pkg::ADDR_UNUSED_A && IDX != pcw_pkg::ADDR_UNUSED_B)
        nx = wdat_d;
    end
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) regs_q[gi] <= pcw_pkg::REG_RESET;
      else regs_q[gi] <= nx;
    end
    assign regs_out[gi*DW +: DW] = regs_q[gi];
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stb_q <= 1'b0;
      wa_q  <= '0;
      wd_q  <= '0;
      oo_q  <= 1'b0;
    end else begin
      stb_q <= wr_d;
      wa_q  <= wr_d ? adr_q : wa_q;
      wd_q  <= wr_d ? wdat_d : wd_q;
      oo_q  <= en_q & ~over_temperature_in;
    end
  end
  assign enabled_out      = en_q;
  assign standby_out      = sb_q;
  assign outputs_on_out   = oo_q;
  assign write_strobe_out = stb_q;
  assign write_addr_out   = wa_q;
  assign write_data_out   = wd_q;
endmodule
`default_nettype wire

// ### rtl/pcw_pkg.sv
// shared constants and types for the pulse-count register link
`default_nettype none
package pcw_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  // interval figures in microseconds
  localparam int unsigned ENABLE_US      = 100;
  localparam int unsigned SHUTDOWN_US    = 2000;
  localparam int unsigned ADDR_HOLD_MIN_US = 400;
  localparam int unsigned ADDR_HOLD_MAX_US = 1000;
  localparam int unsigned DATA_HOLD_US   = 400;
  localparam int unsigned STANDBY_US     = 10000;
  localparam int unsigned PULSE_US       = 10;
  // cycle counts (least times round up; whole here)
  localparam int unsigned ENABLE_CYC     = ENABLE_US * CLK_MHZ;
  localparam int unsigned SHUTDOWN_CYC   = SHUTDOWN_US * CLK_MHZ;
  localparam int unsigned ADDR_HOLD_MIN_CYC = ADDR_HOLD_MIN_US * CLK_MHZ;
  localparam int unsigned ADDR_HOLD_MAX_CYC = ADDR_HOLD_MAX_US * CLK_MHZ;
  localparam int unsigned DATA_HOLD_CYC  = DATA_HOLD_US * CLK_MHZ;
  localparam int unsigned STANDBY_CYC    = STANDBY_US * CLK_MHZ;
  localparam int unsigned PULSE_CYC      = PULSE_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 24;
  localparam int unsigned FILT_CYC       = 3;
  localparam int unsigned NUM_REGS       = 32;
  localparam int unsigned ADDR_W         = 5;
  localparam int unsigned DATA_W         = 6;
  localparam logic [ADDR_W-1:0] ADDR_UNUSED_A = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_UNUSED_B = 5'h04;
  localparam logic [DATA_W-1:0] REG_RESET    = 6'h00;
  typedef enum logic [1:0] {PCW_ADDR, PCW_DATA, PCW_DROP} pcw_phase_t;
  typedef enum logic [2:0] {PCW_H_IDLE, PCW_H_ALOW, PCW_H_AHIGH, PCW_H_AHOLD,
                            PCW_H_DLOW, PCW_H_DHIGH, PCW_H_DHOLD} pcw_hstate_t;
endpackage
`default_nettype wire

// ### rtl/pcw_link_if.sv
// single command wire joining host and receiver
`default_nettype none
interface pcw_link_if;
  logic command_pin;
  modport host (output command_pin);
  modport dev  (input  command_pin);
endinterface
`default_nettype wire

// ### rtl/pcw_host.sv
// host end: sends address and data pulse trains on the command wire
`default_nettype none
module pcw_host #(
  parameter int unsigned ENABLE_CYC = pcw_pkg::ENABLE_CYC * 2,
  parameter int unsigned AHOLD_CYC  = (pcw_pkg::ADDR_HOLD_MIN_CYC + pcw_pkg::ADDR_HOLD_MAX_CYC) / 2,
  parameter int unsigned DHOLD_CYC  = pcw_pkg::DATA_HOLD_CYC * 2,
  parameter int unsigned PULSE_CYC  = pcw_pkg::PULSE_CYC
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rstn_in,
  pcw_link_if.host                   link,
  input  wire logic                  power_on_in,
  input  wire logic                  req_valid_in,
  input  wire logic [pcw_pkg::ADDR_W-1:0] req_addr_in,
  input  wire logic [pcw_pkg::DATA_W-1:0] req_data_in,
  output logic                       req_ready_out,
  output logic                       done_out
);
  localparam int unsigned CW = pcw_pkg::CNT_W;
  pcw_pkg::pcw_hstate_t st_q, st_d;
  logic [CW-1:0] tm_q, tm_d;
  logic [6:0]    left_q, left_d;
  logic [5:0]    dat_q, dat_d;
  logic          pin_q, pin_d, rdy_q, rdy_d, dn_q, dn_d;
  always_comb begin
    st_d   = st_q;
    tm_d   = tm_q + CW'(1);
    left_d = left_q;
    dat_d  = dat_q;
    pin_d  = pin_q;
    rdy_d  = 1'b0;
    dn_d   = 1'b0;
    case (st_q)
      pcw_pkg::PCW_H_IDLE: begin
        pin_d = power_on_in;
        if (!power_on_in) begin
          tm_d = '0;
        end else if (tm_q >= CW'(ENABLE_CYC)) begin
          tm_d  = tm_q;
          rdy_d = 1'b1;
          if (req_valid_in && rdy_q) begin
            // address train first for every write
            left_d = 7'(req_addr_in) + 7'h1;
            dat_d  = req_data_in;
            st_d   = pcw_pkg::PCW_H_ALOW;
            tm_d   = '0;
            pin_d  = 1'b0;
            rdy_d  = 1'b0;
          end
        end
      end
      pcw_pkg::PCW_H_ALOW, pcw_pkg::PCW_H_DLOW: begin
        if (tm_q >= CW'(PULSE_CYC - 1)) begin
          tm_d   = '0;
          pin_d  = 1'b1;
          left_d = left_q - 7'h1;
          st_d   = (st_q == pcw_pkg::PCW_H_ALOW) ? pcw_pkg::PCW_H_AHIGH : pcw_pkg::PCW_H_DHIGH;
        end
      end
      pcw_pkg::PCW_H_AHIGH, pcw_pkg::PCW_H_DHIGH: begin
        if (tm_q >= CW'(PULSE_CYC - 1)) begin
          tm_d = '0;
          if (left_q != '0) begin
            pin_d = 1'b0;
            st_d  = (st_q == pcw_pkg::PCW_H_AHIGH) ? pcw_pkg::PCW_H_ALOW : pcw_pkg::PCW_H_DLOW;
          end else begin
            st_d  = (st_q == pcw_pkg::PCW_H_AHIGH) ? pcw_pkg::PCW_H_AHOLD : pcw_pkg::PCW_H_DHOLD;
          end
        end
      end
      pcw_pkg::PCW_H_AHOLD: begin
        if (tm_q >= CW'(AHOLD_CYC)) begin
          tm_d   = '0;
          pin_d  = 1'b0;
          left_d = 7'(dat_q) + 7'h1;
          st_d   = pcw_pkg::PCW_H_DLOW;
        end
      end
      pcw_pkg::PCW_H_DHOLD: begin
        if (tm_q >= CW'(DHOLD_CYC)) begin
          st_d = pcw_pkg::PCW_H_IDLE;
          dn_d = 1'b1;
          tm_d = CW'(ENABLE_CYC);
        end
      end
      default: st_d = pcw_pkg::PCW_H_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q   <= pcw_pkg::PCW_H_IDLE;
      tm_q   <= '0;
      left_q <= '0;
      dat_q  <= '0;
      pin_q  <= 1'b0;
      rdy_q  <= 1'b0;
      dn_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      tm_q   <= tm_d;
      left_q <= left_d;
      dat_q  <= dat_d;
      pin_q  <= pin_d;
      rdy_q  <= rdy_d;
      dn_q   <= dn_d;
    end
  end
  assign link.command_pin = pin_q;
  assign req_ready_out    = rdy_q;
  assign done_out         = dn_q;
endmodule
`default_nettype wire

// ### test/pcw_asserts.sv
// concurrent checks on the first command wire and its receiver
`default_nettype none
module pcw_asserts #(
  parameter int unsigned ENABLE_CYC   = 20,
  parameter int unsigned SHUTDOWN_CYC = 200,
  parameter int unsigned DHOLD_CYC    = 40,
  parameter int unsigned STANDBY_CYC  = 1000
) (
  input wire logic                                      sys_clk_in,
  input wire logic                                      rstn_in,
  input wire logic                                      command_pin,
  input wire logic                                      over_temperature_in,
  input wire logic                                      enabled_out,
  input wire logic                                      outputs_on_out,
  input wire logic                                      standby_out,
  input wire logic                                      write_strobe_out,
  input wire logic [pcw_pkg::ADDR_W-1:0]                write_addr_out,
  input wire logic [pcw_pkg::DATA_W-1:0]                write_data_out,
  input wire logic [pcw_pkg::NUM_REGS*pcw_pkg::DATA_W-1:0] regs_out
);
  // ==========================================================
  // run lengths of the raw wire level, saturating
  logic [15:0] hi_q, hi_d, lo_q, lo_d;
  logic        gate_ok;
  assign gate_ok = enabled_out && !over_temperature_in;
  always_comb begin
    hi_d = !command_pin ? 16'h0000 : (&hi_q ? hi_q : hi_q + 16'h0001);
    lo_d = command_pin ? 16'h0000 : (&lo_q ? lo_q : lo_q + 16'h0001);
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_new_pulse;
    standby_out ##0 !command_pin [*4] ##1 command_pin;
  endsequence
  property p_strobe_pulse;
    write_strobe_out |=> !write_strobe_out;
  endproperty
  property p_enable;
    $rose(enabled_out) |-> hi_q >= ENABLE_CYC;
  endproperty
  property p_disable;
    $fell(enabled_out) |-> lo_q >= SHUTDOWN_CYC;
  endproperty
  property p_clear;
    !enabled_out [*3] |-> regs_out == '0;
  endproperty
  property p_hot;
    outputs_on_out == $past(gate_ok);
  endproperty
  property p_unused;
    regs_out[3*6 +: 6] == 6'h00 && regs_out[4*6 +: 6] == 6'h00;
  endproperty
  property p_lands;
    write_strobe_out && write_addr_out != pcw_pkg::ADDR_UNUSED_A && write_addr_out != pcw_pkg::ADDR_UNUSED_B
      |-> ##[0:2] regs_out[write_addr_out*6 +: 6] == write_data_out;
  endproperty
  property p_after_hold;
    write_strobe_out |-> hi_q >= DHOLD_CYC && enabled_out;
  endproperty
  property p_standby_in;
    $rose(standby_out) |-> hi_q >= STANDBY_CYC;
  endproperty
  property p_standby_out;
    s_new_pulse |-> ##[1:12] !standby_out;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  a_enable: assert property (p_enable) else $error("enabled too early");
  a_disable: assert property (p_disable) else $error("disabled too early");
  a_clear: assert property (p_clear) else $error("registers kept in shutdown");
  a_hot: assert property (p_hot) else $error("output gate wrong");
  a_unused: assert property (p_unused) else $error("unused register written");
  a_lands: assert property (p_lands) else $error("write did not land");
  a_after_hold: assert property (p_after_hold) else $error("strobe before data hold");
  a_standby_in: assert property (p_standby_in) else $error("standby too early");
  a_standby_out: assert property (p_standby_out) else $error("standby not left");
endmodule
`default_nettype wire

// ### test/test_pulse_count_register_writer.sv
// bench: host and receiver on one wire, a second receiver on a hand-driven wire
`default_nettype none
module test_pulse_count_register_writer;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals and instances
  logic sys_clk = 0, rstn = 0, power_on = 0, valid = 0, hot = 0;
  logic [4:0] addr = 5'h00;
  logic [5:0] data = 6'h00;
  logic ready, done, en1, on1, sb1, stb1, en2, stb2;
  logic [4:0] wa1, wa2;
  logic [5:0] wd1, wd2;
  logic [191:0] regs1, regs2;
  int error_cnt = 0, n_compared = 0, s2 = 0;
  logic [4:0] ta [5] = '{5'h00, 5'h1f, 5'h05, 5'h05, 5'h0a};
  logic [5:0] td [5] = '{6'h00, 6'h3f, 6'h03, 6'h01, 6'h15};
  pcw_link_if link1 ();
  pcw_link_if link2 ();
  // shortened interval counts, receiver side and host side
  localparam int unsigned T_ENA = 20, T_SD = 200, T_AMIN = 40, T_AMAX = 100, T_DH = 40, T_SB = 1000;
  localparam int unsigned H_ENA = 40, H_AHOLD = 70, H_DHOLD = 80, H_PULSE = 4;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (stb2 === 1'b1) s2++;
  pcw_host #(.ENABLE_CYC(H_ENA), .AHOLD_CYC(H_AHOLD), .DHOLD_CYC(H_DHOLD), .PULSE_CYC(H_PULSE)) pcw_host_inst (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .link(link1), .power_on_in(power_on), .req_valid_in(valid),
    .req_addr_in(addr), .req_data_in(data), .req_ready_out(ready), .done_out(done));
  pcw_dev #(.ENABLE_CYC(T_ENA), .SHUTDOWN_CYC(T_SD), .AHOLD_MIN(T_AMIN), .AHOLD_MAX(T_AMAX), .DHOLD_CYC(T_DH),
    .STANDBY_CYC(T_SB)) pcw_dev_inst (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .link(link1), .over_temperature_in(hot), .enabled_out(en1),
    .outputs_on_out(on1), .standby_out(sb1), .write_strobe_out(stb1), .write_addr_out(wa1),
    .write_data_out(wd1), .regs_out(regs1));
  pcw_dev #(.ENABLE_CYC(T_ENA), .SHUTDOWN_CYC(T_SD), .AHOLD_MIN(T_AMIN), .AHOLD_MAX(T_AMAX), .DHOLD_CYC(T_DH),
    .STANDBY_CYC(T_SB)) pcw_dev_inst_2 (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .link(link2), .over_temperature_in(hot), .enabled_out(en2),
    .outputs_on_out(), .standby_out(), .write_strobe_out(stb2), .write_addr_out(wa2),
    .write_data_out(wd2), .regs_out(regs2));
  pcw_asserts #(.ENABLE_CYC(T_ENA), .SHUTDOWN_CYC(T_SD), .DHOLD_CYC(T_DH), .STANDBY_CYC(T_SB)) pcw_asserts_inst (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .command_pin(link1.command_pin), .over_temperature_in(hot),
    .enabled_out(en1), .outputs_on_out(on1), .standby_out(sb1), .write_strobe_out(stb1),
    .write_addr_out(wa1), .write_data_out(wd1), .regs_out(regs1));
  // ==========================================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_hi(input bit use_done, input int bound);
    int i;
    for (i = 0; i < bound && ((use_done ? done : ready) !== 1'b1); i++) tick(1);
    if (i == bound) begin
      check("handshake wait", 32'h0, 32'h1);
      complete_run();
    end
  endtask
  task automatic hwrite(input logic [4:0] a, input logic [5:0] d);
    wait_hi(0, 200);
    addr = a;
    data = d;
    valid = 1'b1;
    tick(1);
    valid = 1'b0;
    wait_hi(1, 4000);
    tick(2);
  endtask
  task automatic train(input int n, input int lo, input int hi);
    repeat (n) begin
      link2.command_pin = 1'b0;
      tick(lo);
      link2.command_pin = 1'b1;
      tick(hi);
    end
  endtask
  task automatic cmd(input int na, input int nd);
    train(na, 4, 5);
    tick(60);
    train(nd, 5, 4);
    tick(70);
  endtask
  task automatic expect2(input int cnt, input logic [4:0] a, input logic [5:0] d);
    check("strobes", 32'(s2), 32'(cnt));
    check("addr2", 32'(wa2), 32'(a));
    check("data2", 32'(wd2), 32'(d));
  endtask
  // ==========================================================
  // main sequence
  initial begin
    link2.command_pin = 1'b0;
    tick(3);
    rstn = 1'b1;
    power_on = 1'b1;
    link2.command_pin = 1'b1;
    wait_hi(0, 200);
    check("enabled", 32'(en1), 32'h1);
    check("enabled2", 32'(en2), 32'h1);
    for (int k = 0; k < 5; k++) begin
      hwrite(ta[k], td[k]);
      check("addr1", 32'(wa1), 32'(ta[k]));
      check("reg1", 32'(regs1[ta[k]*6 +: 6]), 32'(td[k]));
    end
    hwrite(5'h03, 6'h07);
    check("reg3", 32'(regs1[3*6 +: 6]), 32'h0);
    hot = 1'b1;
    tick(3);
    check("outputs hot", 32'(on1), 32'h0);
    check("reg5 hot", 32'(regs1[5*6 +: 6]), 32'h1);
    hot = 1'b0;
    tick(3);
    check("outputs cool", 32'(on1), 32'h1);
    tick(1020);
    check("standby", 32'(sb1), 32'h1);
    hwrite(5'h02, 6'h02);
    check("standby left", 32'(sb1), 32'h0);
    check("data1", 32'(wd1), 32'h2);
    cmd(6, 4);
    expect2(1, 5'h05, 6'h03);
    train(3, 4, 9);
    tick(16);
    train(4, 7, 4);
    tick(60);
    train(2, 6, 4);
    tick(15);
    train(2, 4, 8);
    tick(70);
    expect2(2, 5'h06, 6'h03);
    cmd(32, 64);
    expect2(3, 5'h1f, 6'h3f);
    train(33, 4, 5);
    tick(60);
    cmd(8, 10);
    expect2(4, 5'h07, 6'h09);
    cmd(9, 65);
    check("no write", 32'(s2), 32'h4);
    check("reg8", 32'(regs2[8*6 +: 6]), 32'h0);
    train(4, 4, 5);
    tick(150);
    cmd(3, 5);
    expect2(5, 5'h02, 6'h04);
    train(2, 4, 5);
    tick(45);
    train(3, 4, 5);
    tick(300);
    expect2(6, 5'h01, 6'h02);
    cmd(10, 2);
    expect2(7, 5'h09, 6'h01);
    power_on = 1'b0;
    link2.command_pin = 1'b0;
    tick(230);
    check("disabled", 32'(en1), 32'h0);
    check("regs cleared", 32'(|regs1), 32'h0);
    check("regs2 cleared", 32'(|regs2), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
